// ===== inc/gpgp_params.svh
// register indices, field positions, codes and reset values of the gpio group
// assumes byte address = 4 * index on a 32-bit bus
`ifndef GPGP_PARAMS_SVH
`define GPGP_PARAMS_SVH
`define GP_IDX_DIR 6'h00
`define GP_IDX_DSET 6'h01
`define GP_IDX_DCLR 6'h02
`define GP_IDX_DTGL 6'h03
`define GP_IDX_OUT 6'h04
`define GP_IDX_OSET 6'h05
`define GP_IDX_OCLR 6'h06
`define GP_IDX_OTGL 6'h07
`define GP_IDX_IN 6'h08
`define GP_IDX_FLG 6'h09
`define GP_IDX_CTL 6'h0A
`define GP_IDX_CFG0 6'h10
`define GP_IDX_VP 6'h20
`define GP_IDX_VP_LAST 6'h23
`define GP_VP_DIR 2'h0
`define GP_VP_OUT 2'h1
`define GP_VP_IN 2'h2
`define GP_ADDR_LO 2'h0
`define GP_CFG_MASK 8'h8F
`define GP_CTL_SLEW 0
`define GP_SEN_OFF 3'h0
`define GP_SEN_ANY 3'h1
`define GP_SEN_RISE 3'h2
`define GP_SEN_FALL 3'h3
`define GP_SEN_INOFF 3'h4
`define GP_SEN_LOW 3'h5
`define GP_RST_BYTE 8'h00
`define GP_RST_WORD 32'h00000000
`endif

// ===== inc/gpgp_pkg.sv
// types shared by the gpio group logic
// assumes the constants header is compiled alongside
package gpgp_pkg;
  typedef struct packed {
    logic flip;
    logic [2:0] rsv;
    logic weak_high;
    logic [2:0] sense;
  } gpgp_cfg_t;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wdata;
  } gpgp_req_t;
endpackage

// ===== core/gpgp_port.sv
// gpio group: pad sampling, change sense flags, pad config, fast alias window
// assumes an APB master on REF_CLK_IN and pad inputs synchronous to it
// Behaviour
// - pad level register follows enabled pads
// - write to pad levels toggles drive levels
// - disabled input buffer holds sampled level
// - change flag sets on selected sense
// - writing one clears a change flag
// - one slew limit bit for all pads
// - per-pad config at 0x10 plus index
// - polarity flip inverts driven and sampled value
// - weak pull-high only on input-only pads
// - sense codes both, rising, falling edges
// - code 0 keeps buffer, no flags
// - code 4 disables buffer and flags
// - code 5 flags while level low
// - alias window mirrors four primary registers
// - drive enable one drives, zero input-only
// - drive enable never touches input buffer
// - drive level sets pad when driving
// - levels, flags, control at 8/9/A, reset zero
// - set, clear, toggle helpers on drive enable
`timescale 1ns/1ns
`include "gpgp_params.svh"
module gpgp_port
  import gpgp_pkg::*;
#(
  parameter int NUM_PADS = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // pads
  input wire logic [NUM_PADS-1:0] PAD_IN,
  output logic [NUM_PADS-1:0] PAD_OUT,
  output logic [NUM_PADS-1:0] PAD_OE_N_OUT,
  output logic [NUM_PADS-1:0] PAD_PULL_OUT,
  output logic [NUM_PADS-1:0] PAD_INBUF_OUT,
  output logic SLEW_LIMIT_OUT
);

  if (NUM_PADS < 1 || NUM_PADS > 8) begin : g_chk_pads
    $error("NUM_PADS must be 1 to 8");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must be 8 to 32");
  end

  localparam int NP = NUM_PADS;

  // port state
  logic [NP-1:0] drive_enable_ff;
  logic [NP-1:0] nxt_drive_enable;
  logic [NP-1:0] drive_level_ff;
  logic [NP-1:0] nxt_drive_level;
  logic [NP-1:0] pad_levels_ff;
  logic [NP-1:0] nxt_pad_levels;
  logic [NP-1:0] change_flags_ff;
  logic [NP-1:0] nxt_change_flags;
  logic slew_ff;
  logic nxt_slew;
  gpgp_cfg_t cfg_ff [NP];
  gpgp_cfg_t nxt_cfg [NP];
  logic [NP-1:0] sync1_ff;
  logic [NP-1:0] nxt_sync1;
  logic [NP-1:0] sync2_ff;
  logic [NP-1:0] nxt_sync2;
  // registered pad outputs
  logic [NP-1:0] pad_out_ff;
  logic [NP-1:0] nxt_pad_out;
  logic [NP-1:0] oe_n_ff;
  logic [NP-1:0] nxt_oe_n;
  logic [NP-1:0] pull_ff;
  logic [NP-1:0] nxt_pull;
  logic [NP-1:0] inbuf_ff;
  logic [NP-1:0] nxt_inbuf;
  // bus
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  // decode
  gpgp_req_t req;
  logic [5:0] pidx;
  logic setup;
  logic wr_go;
  logic hit;
  logic is_cfg;
  logic [2:0] cfg_sel;
  logic [7:0] rd;
  logic [NP-1:0] w_data;
  logic [NP-1:0] clr;
  logic [NP-1:0] en_vec;
  logic [NP-1:0] hit_vec;
  logic [NP-1:0] flip_vec;

  // alias window lands on the same storage, so both views stay coherent
  function automatic logic [5:0] gp_remap(input logic [5:0] i);
    logic [5:0] d;
    d = i - `GP_IDX_VP;
    gp_remap = i;
    if (i >= `GP_IDX_VP && i <= `GP_IDX_VP_LAST) begin
      if (d[1:0] == `GP_VP_DIR) begin
        gp_remap = `GP_IDX_DIR;
      end else if (d[1:0] == `GP_VP_OUT) begin
        gp_remap = `GP_IDX_OUT;
      end else if (d[1:0] == `GP_VP_IN) begin
        gp_remap = `GP_IDX_IN;
      end else begin
        gp_remap = `GP_IDX_FLG;
      end
    end
  endfunction

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign req.idx = PADDR_IN[7:2];
  assign req.wdata = PWDATA_IN[7:0];
  assign pidx = gp_remap(req.idx);
  assign w_data = req.wdata[NP-1:0];
  assign cfg_sel = 3'(pidx - `GP_IDX_CFG0);
  assign is_cfg = pidx >= `GP_IDX_CFG0 && pidx < `GP_IDX_CFG0 + 6'(NP);
  // a write lands only at the access edge that sees our ready
  assign wr_go = PSEL_IN & PENABLE_IN & pready_ff & PWRITE_IN & PSTRB_IN[0] & ~pslverr_ff;

  // read mux and map check
  always_comb begin
    hit = 1'b1;
    rd = `GP_RST_BYTE;
    if (PADDR_IN[1:0] != `GP_ADDR_LO || (PADDR_IN >> 8) != '0) begin
      hit = 1'b0;
    end else if (pidx >= `GP_IDX_DIR && pidx <= `GP_IDX_DTGL) begin
      rd = 8'(drive_enable_ff);
    end else if (pidx >= `GP_IDX_OUT && pidx <= `GP_IDX_OTGL) begin
      rd = 8'(drive_level_ff);
    end else if (pidx == `GP_IDX_IN) begin
      rd = 8'(pad_levels_ff);
    end else if (pidx == `GP_IDX_FLG) begin
      rd = 8'(change_flags_ff);
    end else if (pidx == `GP_IDX_CTL) begin
      rd = 8'(slew_ff);
    end else if (is_cfg) begin
      rd = cfg_ff[cfg_sel] & `GP_CFG_MASK;
    end else begin
      hit = 1'b0;
    end
  end

  // no wait state: data and ready are captured at the setup edge
  always_comb begin
    nxt_pready = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = {24'h000000, rd};
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      prdata_ff <= `GP_RST_WORD;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // software writes
  always_comb begin
    nxt_drive_enable = drive_enable_ff;
    nxt_drive_level = drive_level_ff;
    nxt_slew = slew_ff;
    nxt_cfg = cfg_ff;
    clr = '0;
    if (wr_go) begin
      if (pidx == `GP_IDX_DIR) begin
        nxt_drive_enable = w_data;
      end else if (pidx == `GP_IDX_DSET) begin
        nxt_drive_enable = drive_enable_ff | w_data;
      end else if (pidx == `GP_IDX_DCLR) begin
        nxt_drive_enable = drive_enable_ff & ~w_data;
      end else if (pidx == `GP_IDX_DTGL) begin
        nxt_drive_enable = drive_enable_ff ^ w_data;
      end else if (pidx == `GP_IDX_OUT) begin
        nxt_drive_level = w_data;
      end else if (pidx == `GP_IDX_OSET) begin
        nxt_drive_level = drive_level_ff | w_data;
      end else if (pidx == `GP_IDX_OCLR) begin
        nxt_drive_level = drive_level_ff & ~w_data;
      end else if (pidx == `GP_IDX_OTGL) begin
        nxt_drive_level = drive_level_ff ^ w_data;
      end else if (pidx == `GP_IDX_IN) begin
        // the written value is not stored in the level register
        nxt_drive_level = drive_level_ff ^ w_data;
      end else if (pidx == `GP_IDX_FLG) begin
        clr = w_data;
      end else if (pidx == `GP_IDX_CTL) begin
        nxt_slew = req.wdata[`GP_CTL_SLEW];
      end else if (is_cfg) begin
        nxt_cfg[cfg_sel] = req.wdata & `GP_CFG_MASK;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      drive_enable_ff <= '0;
      drive_level_ff <= '0;
      slew_ff <= 1'b0;
      for (int i = 0; i < NP; i++) begin
        cfg_ff[i] <= `GP_RST_BYTE;
      end
    end else begin
      drive_enable_ff <= nxt_drive_enable;
      drive_level_ff <= nxt_drive_level;
      slew_ff <= nxt_slew;
      cfg_ff <= nxt_cfg;
    end
  end

  // pad sampling, sense and pad drive
  always_comb begin
    logic rise;
    logic fall;
    logic [2:0] s;
    rise = 1'b0;
    fall = 1'b0;
    s = `GP_SEN_OFF;
    en_vec = '0;
    hit_vec = '0;
    flip_vec = '0;
    nxt_pad_levels = pad_levels_ff;
    nxt_change_flags = change_flags_ff;
    nxt_pad_out = pad_out_ff;
    nxt_oe_n = oe_n_ff;
    nxt_pull = pull_ff;
    nxt_inbuf = inbuf_ff;
    for (int i = 0; i < NP; i++) begin
      s = cfg_ff[i].sense;
      flip_vec[i] = cfg_ff[i].flip;
      // buffer depends on sense code only, never on drive enable
      en_vec[i] = s != `GP_SEN_INOFF;
      if (en_vec[i]) begin
        nxt_pad_levels[i] = sync2_ff[i];
      end else begin
        nxt_pad_levels[i] = pad_levels_ff[i];
      end
      // edges are judged against the last sampled level
      rise = en_vec[i] & sync2_ff[i] & ~pad_levels_ff[i];
      fall = en_vec[i] & ~sync2_ff[i] & pad_levels_ff[i];
      case (s)
        `GP_SEN_ANY: hit_vec[i] = rise | fall;
        `GP_SEN_RISE: hit_vec[i] = rise;
        `GP_SEN_FALL: hit_vec[i] = fall;
        `GP_SEN_LOW: hit_vec[i] = ~sync2_ff[i];
        default: hit_vec[i] = 1'b0;
      endcase
      // a new event beats a clear in the same cycle
      nxt_change_flags[i] = (change_flags_ff[i] & ~clr[i]) | hit_vec[i];
      nxt_pad_out[i] = drive_level_ff[i] ^ cfg_ff[i].flip;
      nxt_oe_n[i] = ~drive_enable_ff[i];
      nxt_pull[i] = cfg_ff[i].weak_high & ~drive_enable_ff[i];
      nxt_inbuf[i] = en_vec[i];
    end
  end

  // flip before the synchroniser so sense sees the logical level
  always_comb begin
    nxt_sync1 = PAD_IN ^ flip_vec;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      pad_levels_ff <= '0;
      change_flags_ff <= '0;
      pad_out_ff <= '0;
      oe_n_ff <= '1;
      pull_ff <= '0;
      inbuf_ff <= '1;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      pad_levels_ff <= nxt_pad_levels;
      change_flags_ff <= nxt_change_flags;
      pad_out_ff <= nxt_pad_out;
      oe_n_ff <= nxt_oe_n;
      pull_ff <= nxt_pull;
      inbuf_ff <= nxt_inbuf;
    end
  end

  assign PRDATA_OUT = prdata_ff;
  assign PREADY_OUT = pready_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign PAD_OUT = pad_out_ff;
  assign PAD_OE_N_OUT = oe_n_ff;
  assign PAD_PULL_OUT = pull_ff;
  assign PAD_INBUF_OUT = inbuf_ff;
  assign SLEW_LIMIT_OUT = slew_ff;

  // checks
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_ctl_write;
    wr_go && pidx == `GP_IDX_CTL;
  endsequence

  property p_ready;
    s_setup |=> PREADY_OUT ##1 (!PREADY_OUT || $past(setup));
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");

  property p_toggle;
    wr_go && pidx == `GP_IDX_IN |=> drive_level_ff == ($past(drive_level_ff) ^ $past(w_data));
  endproperty
  a_toggle: assert property (p_toggle) else $error("level write did not toggle");

  property p_hold;
    1'b1 |=> ((pad_levels_ff ^ $past(pad_levels_ff)) & ~$past(en_vec)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("disabled pad level changed");

  property p_follow;
    1'b1 |=> ((pad_levels_ff ^ $past(sync2_ff)) & $past(en_vec)) == '0;
  endproperty
  a_follow: assert property (p_follow) else $error("pad level not sampled");

  property p_flag_set;
    1'b1 |=> (change_flags_ff & $past(hit_vec)) == $past(hit_vec);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("sense hit lost");

  property p_flag_clr;
    wr_go && pidx == `GP_IDX_FLG |=> (change_flags_ff & $past(w_data) & ~$past(hit_vec)) == '0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_slew;
    s_ctl_write |=> ##1 SLEW_LIMIT_OUT == $past(PWDATA_IN[0], 2);
  endproperty
  a_slew: assert property (p_slew) else $error("slew bit wrong");

  property p_oe;
    1'b1 |=> PAD_OE_N_OUT == ~$past(drive_enable_ff);
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");

  property p_pad_out;
    1'b1 |=> PAD_OUT == ($past(drive_level_ff) ^ $past(flip_vec));
  endproperty
  a_pad_out: assert property (p_pad_out) else $error("pad drive wrong");

endmodule

// ===== sim/gpgp_pad_model.sv
// pad model: the outside world seen by the eight gpio group pads
// assumes pad controls are registered on the same clock as the port
`timescale 1ns/1ns
module gpgp_pad_model #(
  parameter int N = 8
) (
  // clock
  input wire logic clk,
  // device side
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] oe_n,
  input wire logic [N-1:0] pull,
  // external drivers set by the bench
  input wire logic [N-1:0] ext_drv,
  input wire logic [N-1:0] ext_lvl,
  // resolved pad level
  output logic [N-1:0] pad_in
);
  logic [N-1:0] last = '0;
  always @(posedge clk) last <= pad_in;
  // a pad nobody drives or pulls high shows no stale level: it flips every cycle
  for (genvar i = 0; i < N; i++) begin : g_pad
    assign pad_in[i] = !oe_n[i] ? pad_out[i] : ext_drv[i] ? ext_lvl[i] :
                       pull[i] ? 1'b1 : ~last[i];
  end
endmodule

// ===== sim/gpgp_port_bench.sv
// self-checking bench for the gpio group port over apb
// assumes the pad model closes the loop from pad outputs to pad inputs
`timescale 1ns/1ns
module gpgp_port_bench;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] ext_drv = 8'hFF;
  logic [7:0] ext_lvl = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, slew, err;
  logic [7:0] pad_in, pad_out, oe_n, pull, inbuf, q;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  gpgp_port gpgp_port_i (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE_N_OUT(oe_n), .PAD_PULL_OUT(pull), .PAD_INBUF_OUT(inbuf),
    .SLEW_LIMIT_OUT(slew));
  gpgp_pad_model gpgp_pad_model_i (.clk(clk), .pad_out(pad_out), .oe_n(oe_n),
    .pull(pull), .ext_drv(ext_drv), .ext_lvl(ext_lvl), .pad_in(pad_in));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // idle cycles also release the bus
  task automatic wt(input int n);
    psel <= 0;
    pen <= 0;
    repeat (n) @(posedge clk);
  endtask
  // select stays up at the end so a back-to-back setup never double-drives it
  // no wait count of its own: only the run timeout ends a hung transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
    apb(0, a, 8'h00);
    chk(s, e, q);
  endtask
  task automatic t_reset;
    rd(8'h20, 8'h00, "levels");
    rd(8'h24, 8'h00, "flags");
    rd(8'h28, 8'h00, "control");
    rd(8'h2C, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h0, err});
    wt(1);
    $display("test reset done");
  endtask
  task automatic t_drive;
    apb(1, 8'h00, 8'hFF);
    ext_drv <= 8'h00;
    apb(1, 8'h84, 8'hA5);
    wt(6);
    chk("pad_out", 8'hA5, pad_out);
    chk("oe_n", 8'h00, oe_n);
    chk("inbuf", 8'hFF, inbuf);
    rd(8'h20, 8'hA5, "levels");
    rd(8'h88, 8'hA5, "alias levels");
    apb(1, 8'h20, 8'h0F);
    rd(8'h10, 8'hAA, "drive level");
    apb(1, 8'h14, 8'h05);
    apb(1, 8'h18, 8'h04);
    rd(8'h14, 8'hAB, "level helpers");
    apb(1, 8'h1C, 8'h01);
    rd(8'h84, 8'hAA, "alias drive level");
    ext_drv <= 8'h0F;
    apb(1, 8'h08, 8'h0F);
    rd(8'h00, 8'hF0, "drive enable");
    apb(1, 8'h0C, 8'hFF);
    rd(8'h80, 8'h0F, "alias drive enable");
    wt(1);
    $display("test drive done");
  endtask
  task automatic t_flip;
    ext_drv <= 8'h02;
    apb(1, 8'h00, 8'hFD);
    apb(1, 8'h40, 8'h80);
    wt(6);
    chk("pad_out", 8'hAB, pad_out);
    rd(8'h20, 8'hA8, "levels");
    apb(1, 8'h40, 8'h00);
    apb(1, 8'h5C, 8'hFF);
    rd(8'h5C, 8'h8F, "config 7");
    apb(1, 8'h5C, 8'h00);
    wt(1);
    $display("test flip done");
  endtask
  task automatic t_pull_slew;
    apb(1, 8'h48, 8'h08);
    apb(1, 8'h08, 8'h04);
    wt(2);
    chk("pull", 8'h04, pull);
    apb(1, 8'h04, 8'h04);
    wt(2);
    chk("pull", 8'h00, pull);
    apb(1, 8'h28, 8'h01);
    wt(2);
    chk("slew", 8'h01, {7'h0, slew});
    apb(1, 8'h28, 8'h00);
    wt(2);
    chk("slew", 8'h00, {7'h0, slew});
    apb(1, 8'h48, 8'h00);
    wt(1);
    $display("test pull and slew done");
  endtask
  task automatic t_sense;
    logic [5:0] er, ef;
    er = 6'b100110;
    ef = 6'b101010;
    for (int c = 0; c < 6; c++) begin
      apb(1, 8'h44, {5'h0, c[2:0]});
      wt(5);
      apb(1, 8'h24, 8'h02);
      ext_lvl <= 8'h02;
      wt(5);
      chk("inbuf", c == 4 ? 8'hFD : 8'hFF, inbuf);
      rd(8'h24, {6'h0, er[c], 1'b0}, "rise flag");
      apb(0, 8'h20, 8'h00);
      chk("level", c == 4 ? 8'h00 : 8'h02, q & 8'h02);
      apb(1, 8'h24, 8'h02);
      ext_lvl <= 8'h00;
      wt(5);
      rd(8'h24, {6'h0, ef[c], 1'b0}, "fall flag");
    end
    apb(1, 8'h44, 8'h01);
    apb(1, 8'h24, 8'hFF);
    ext_lvl <= 8'h02;
    wt(5);
    apb(1, 8'h8C, 8'hFD);
    rd(8'h24, 8'h02, "kept flag");
    apb(1, 8'h8C, 8'h02);
    rd(8'h8C, 8'h00, "cleared flag");
    wt(1);
    $display("test sense done");
  endtask
  // reset in mid-run, after control and drive enable were left non-zero
  task automatic t_rerun;
    apb(1, 8'h28, 8'h01);
    ext_drv <= 8'hFF;
    ext_lvl <= 8'h00;
    rst <= 1;
    wt(3);
    rst <= 0;
    wt(2);
    chk("oe_n", 8'hFF, oe_n);
    chk("slew", 8'h00, {7'h0, slew});
    rd(8'h00, 8'h00, "drive enable");
    rd(8'h20, 8'h00, "levels");
    rd(8'h24, 8'h00, "flags");
    rd(8'h28, 8'h00, "control");
    wt(1);
    $display("test mid-run reset done");
  endtask
  initial begin
    wt(10);
    rst <= 0;
    wt(2);
    t_reset;
    t_drive;
    t_flip;
    t_pull_slew;
    t_sense;
    t_rerun;
    end_sim;
  end
endmodule
